// [hdl/bit_sync.sv]
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/100ps
`default_nettype none

module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st_r;
  sync_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule : bit_sync

`default_nettype wire

// [hdl/link_write_port.sv]
// Link-clock capture of register writes, handed over by a toggle
`timescale 1ns/100ps
`default_nettype none
`include "meter_reset_params.svh"

module link_write_port (
  input  wire logic               link_clk,
  input  wire logic               rst,
  input  wire logic               link_wr_en,
  input  wire logic [`ADDR_W-1:0] link_addr,
  input  wire logic [`REG_W-1:0]  link_wdata,
  output logic                    wr_toggle,
  output logic      [`ADDR_W-1:0] wr_addr,
  output logic      [`REG_W-1:0]  wr_data
);

  typedef struct packed {
    logic               tog;
    logic [`ADDR_W-1:0] addr;
    logic [`REG_W-1:0]  data;
  } link_s;

  link_s st_r;
  link_s st_nxt;

  // Address and data stay still until the next write
  always_comb begin
    st_nxt = st_r;
    if (link_wr_en) begin
      st_nxt.tog  = ~st_r.tog;
      st_nxt.addr = link_addr;
      st_nxt.data = link_wdata;
    end
  end

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wr_toggle = st_r.tog;
  assign wr_addr   = st_r.addr;
  assign wr_data   = st_r.data;

endmodule : link_write_port

`default_nettype wire

// [hdl/meter_reset_params.svh]
// Constants for the reset and serial-port sequencer
`ifndef METER_RESET_PARAMS_SVH
`define METER_RESET_PARAMS_SVH

`define CLK_KHZ            25000
`define HOLD_MS            26
`define WAKE_MS            40
`define HWRST_MIN_US       10
`define CNT_W              20
`define REG_W              16
`define ADDR_W             3

`define PORT_LOCK_BIT      1
`define SOFT_RESET_BIT     7
`define RESET_DONE_BIT     15
`define SPI_SELECT_EDGES   3

`define RUN_START          16'h0001
`define PORT_CFG_DEFAULT   16'h0000
`define MAIN_SETUP_DEFAULT 16'h0000
`define OCUR_DEFAULT       16'h0000

`define ADDR_STATUS_ONE    3'h0
`define ADDR_MAIN_SETUP    3'h1
`define ADDR_PORT_CFG      3'h2
`define ADDR_OCUR          3'h3
`define ADDR_RUN           3'h4

`endif

// [hdl/meter_reset_pkg.sv]
// Types shared by the reset and serial-port sequencer
package meter_reset_pkg;

  typedef enum logic [1:0] {
    PM_NORMAL,
    PM_RED_A,
    PM_RED_B,
    PM_SLEEP
  } power_mode_e;

  typedef enum logic [2:0] {
    SEQ_INACTIVE,
    SEQ_LOWPWR,
    SEQ_WAKE,
    SEQ_NORMAL,
    SEQ_HWRESET,
    SEQ_SWRESET
  } seq_state_e;

endpackage : meter_reset_pkg

// [hdl/meter_reset_port_sequencer.sv]
// Power-up, hardware and software reset sequencer with serial-port choice
`timescale 1ns/100ps
`default_nettype none
`include "meter_reset_params.svh"

module meter_reset_port_sequencer #(
  parameter int              HOLD_CYC   = `HOLD_MS * `CLK_KHZ,
  parameter int              WAKE_CYC   = `WAKE_MS * `CLK_KHZ,
  parameter logic [`REG_W-1:0] OCUR_RESET = `OCUR_DEFAULT
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          link_clk,
  input  wire logic                          supply_ok,
  input  wire logic                          power_mode_pin_zero,
  input  wire logic                          power_mode_pin_one,
  input  wire logic                          reset_pin_n,
  input  wire logic                          port_select_pin,
  input  wire logic                          link_wr_en,
  input  wire logic [`ADDR_W-1:0]            link_addr,
  input  wire logic [`REG_W-1:0]             link_wdata,
  output logic                               chip_active,
  output meter_reset_pkg::power_mode_e       power_state,
  output logic                               interrupt_line_one_n,
  output logic      [`REG_W-1:0]             status_one,
  output logic      [`REG_W-1:0]             main_setup,
  output logic      [`REG_W-1:0]             port_config,
  output logic      [`REG_W-1:0]             overcurrent_threshold,
  output logic                               spi_selected,
  output logic                               port_locked,
  output logic                               dsp_run,
  output logic                               defaults_load
);

  localparam int RST_CYC = (`HWRST_MIN_US * `CLK_KHZ + 999) / 1000;
  localparam logic [`CNT_W-1:0] HOLD_END = `CNT_W'(HOLD_CYC - 1);
  localparam logic [`CNT_W-1:0] WAKE_END = `CNT_W'(WAKE_CYC - 1);
  localparam logic [`CNT_W-1:0] RST_MIN  = `CNT_W'(RST_CYC);
  localparam logic [1:0]        EDGE_END = 2'(`SPI_SELECT_EDGES - 1);

  typedef struct packed {
    meter_reset_pkg::seq_state_e  state;
    meter_reset_pkg::power_mode_e pmode;
    logic [`CNT_W-1:0]            cnt;
    logic [1:0]                   edges;
    logic                         spi;
    logic                         lock;
    logic                         powered;
    logic                         done;
    logic                         run;
    logic                         load;
    logic                         tog_prev;
    logic                         ps_prev;
    logic [`REG_W-1:0]            setup;
    logic [`REG_W-1:0]            port_cfg;
    logic [`REG_W-1:0]            ocur;
  } seq_s;

  seq_s st_r;
  seq_s st_nxt;

  logic               wr_toggle;
  logic [`ADDR_W-1:0] wr_addr;
  logic [`REG_W-1:0]  wr_data;
  logic [5:0]         pins_s;
  logic               sup_s;
  logic               pm0_s;
  logic               pm1_s;
  logic               rstpin_s;
  logic               ps_s;
  logic               tog_s;
  logic               wr;
  logic               fall;
  logic               clr_done;
  logic               set_done;
  meter_reset_pkg::power_mode_e mode;

  link_write_port u_link (
    .link_clk   (link_clk),
    .rst        (rst),
    .link_wr_en (link_wr_en),
    .link_addr  (link_addr),
    .link_wdata (link_wdata),
    .wr_toggle  (wr_toggle),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data)
  );

  bit_sync #(.W(6)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({supply_ok, power_mode_pin_zero, power_mode_pin_one,
           reset_pin_n, port_select_pin, wr_toggle}),
    .q   (pins_s)
  );

  assign {sup_s, pm0_s, pm1_s, rstpin_s, ps_s, tog_s} = pins_s;

  // Mode pins: both high sleep, one low with zero high normal
  always_comb begin
    case ({pm1_s, pm0_s})
      2'b11:   mode = meter_reset_pkg::PM_SLEEP;
      2'b01:   mode = meter_reset_pkg::PM_NORMAL;
      2'b00:   mode = meter_reset_pkg::PM_RED_A;
      default: mode = meter_reset_pkg::PM_RED_B;
    endcase
  end

  assign wr   = tog_s != st_r.tog_prev;
  assign fall = st_r.ps_prev & ~ps_s;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.load     = 1'b0;
    st_nxt.tog_prev = tog_s;
    st_nxt.ps_prev  = ps_s;
    set_done        = 1'b0;
    clr_done        = 1'b0;
    case (st_r.state)
      meter_reset_pkg::SEQ_INACTIVE: begin
        if (st_r.cnt == HOLD_END) begin
          st_nxt.state = meter_reset_pkg::SEQ_LOWPWR;
          st_nxt.pmode = meter_reset_pkg::PM_SLEEP;
          st_nxt.cnt   = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      meter_reset_pkg::SEQ_LOWPWR: begin
        if (st_r.pmode == meter_reset_pkg::PM_SLEEP &&
            mode == meter_reset_pkg::PM_NORMAL || st_r.pmode != meter_reset_pkg::PM_SLEEP &&
            mode == meter_reset_pkg::PM_NORMAL) begin
          st_nxt.state = meter_reset_pkg::SEQ_WAKE;
          st_nxt.cnt   = '0;
          st_nxt.done  = 1'b0;
        end else begin
          st_nxt.pmode = mode;
        end
      end
      meter_reset_pkg::SEQ_WAKE: begin
        if (st_r.cnt == WAKE_END) begin
          st_nxt.state = meter_reset_pkg::SEQ_NORMAL;
          st_nxt.pmode = meter_reset_pkg::PM_NORMAL;
          st_nxt.load  = 1'b1;
          st_nxt.setup = `MAIN_SETUP_DEFAULT;
          st_nxt.run   = 1'b0;
          st_nxt.edges = '0;
          set_done     = 1'b1;
          if (!st_r.powered) begin
            st_nxt.powered  = 1'b1;
            st_nxt.port_cfg = `PORT_CFG_DEFAULT;
            st_nxt.ocur     = OCUR_RESET;
            st_nxt.spi      = 1'b0;
            st_nxt.lock     = 1'b0;
          end
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      meter_reset_pkg::SEQ_NORMAL: begin
        if (mode != meter_reset_pkg::PM_NORMAL) begin
          // Port choice and lock carry through reduced states
          st_nxt.state = meter_reset_pkg::SEQ_LOWPWR;
          st_nxt.pmode = mode;
        end else if (!rstpin_s) begin
          st_nxt.state = meter_reset_pkg::SEQ_HWRESET;
          st_nxt.cnt   = '0;
          st_nxt.done  = 1'b0;
        end else if (st_r.setup[`SOFT_RESET_BIT]) begin
          st_nxt.state = meter_reset_pkg::SEQ_SWRESET;
          st_nxt.done  = 1'b0;
        end else begin
          if (wr) begin
            case (wr_addr)
              `ADDR_STATUS_ONE: clr_done = wr_data[`RESET_DONE_BIT];
              `ADDR_MAIN_SETUP: st_nxt.setup = wr_data;
              `ADDR_OCUR:       st_nxt.ocur = wr_data;
              `ADDR_RUN:        st_nxt.run = wr_data == `RUN_START;
              `ADDR_PORT_CFG: begin
                st_nxt.port_cfg = wr_data;
                if (st_r.spi) begin
                  st_nxt.lock = 1'b1;
                end else if (wr_data[`PORT_LOCK_BIT]) begin
                  st_nxt.lock = 1'b1;
                end
              end
              default: st_nxt.run = st_r.run;
            endcase
          end
          if (fall && !st_r.lock && !st_r.spi) begin
            if (st_r.edges == EDGE_END) begin
              st_nxt.spi   = 1'b1;
              st_nxt.edges = '0;
            end else begin
              st_nxt.edges = st_r.edges + 1'b1;
            end
          end
        end
      end
      meter_reset_pkg::SEQ_HWRESET: begin
        if (rstpin_s) begin
          st_nxt.state = meter_reset_pkg::SEQ_NORMAL;
          if (st_r.cnt >= RST_MIN) begin
            st_nxt.load     = 1'b1;
            st_nxt.setup    = `MAIN_SETUP_DEFAULT;
            st_nxt.port_cfg = `PORT_CFG_DEFAULT;
            st_nxt.ocur     = OCUR_RESET;
            st_nxt.spi      = 1'b0;
            st_nxt.lock     = 1'b0;
            st_nxt.edges    = '0;
            st_nxt.run      = 1'b0;
            set_done        = 1'b1;
          end
        end else if (st_r.cnt != RST_MIN) begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      meter_reset_pkg::SEQ_SWRESET: begin
        // Port config, threshold and lock are left alone
        st_nxt.state = meter_reset_pkg::SEQ_NORMAL;
        st_nxt.load  = 1'b1;
        st_nxt.setup = `MAIN_SETUP_DEFAULT;
        st_nxt.run   = 1'b0;
        st_nxt.edges = '0;
        set_done     = 1'b1;
      end
      default: begin
        st_nxt.state = meter_reset_pkg::SEQ_INACTIVE;
        st_nxt.cnt   = '0;
      end
    endcase
    // Set beats a clear in the same cycle
    st_nxt.done = set_done | (st_nxt.done & ~clr_done);
    // Supply loss is a power-down: everything but the toggle and select edge history back to start
    if (!sup_s) begin
      st_nxt          = '0;
      st_nxt.tog_prev = tog_s;
      st_nxt.ps_prev  = ps_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chip_active           = st_r.state != meter_reset_pkg::SEQ_INACTIVE;
  assign power_state           = st_r.pmode;
  assign interrupt_line_one_n  = ~st_r.done;
  assign status_one            = {st_r.done, 15'h0000};
  assign main_setup            = st_r.setup;
  assign port_config           = st_r.port_cfg;
  assign overcurrent_threshold = st_r.ocur;
  assign spi_selected          = st_r.spi;
  assign port_locked           = st_r.lock;
  assign dsp_run               = st_r.run;
  assign defaults_load         = st_r.load;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_HOLD_TIME: assert property (
    st_r.state == meter_reset_pkg::SEQ_INACTIVE &&
    st_nxt.state == meter_reset_pkg::SEQ_LOWPWR |-> st_r.cnt == HOLD_END)
    else $error("left inactive state before hold time");

  AST_WAKE_BOUND: assert property (
    st_r.state == meter_reset_pkg::SEQ_WAKE |-> st_r.cnt <= WAKE_END)
    else $error("wake counter passed its bound");

  AST_HW_DONE: assert property (
    st_r.state == meter_reset_pkg::SEQ_HWRESET && rstpin_s && st_r.cnt >= RST_MIN && sup_s
    |=> st_r.done && !interrupt_line_one_n && !st_r.spi && st_r.port_cfg == `PORT_CFG_DEFAULT)
    else $error("hardware reset did not restore defaults");

  AST_SPI_PICK: assert property (
    $rose(st_r.spi) |-> $past(st_r.edges) == EDGE_END && !$past(st_r.lock))
    else $error("spi chosen without three edges");

  AST_I2C_LOCK: assert property (
    st_r.lock && !st_r.spi && sup_s |=> !st_r.spi)
    else $error("locked two-wire port switched");

  AST_SPI_STAY: assert property (
    st_r.lock && st_r.spi && sup_s && st_r.state != meter_reset_pkg::SEQ_HWRESET
    |=> st_r.spi && st_r.lock)
    else $error("locked spi port lost");

  AST_DONE_CLR: assert property (
    st_r.done && clr_done && !set_done |=> !st_r.done ##0 interrupt_line_one_n)
    else $error("done flag not cleared by write");

  AST_RUN_IDLE: assert property (
    st_r.load |-> !st_r.run)
    else $error("processor running after reset");

  AST_RST_IGNORE: assert property (
    st_r.state == meter_reset_pkg::SEQ_LOWPWR
    |=> st_r.state != meter_reset_pkg::SEQ_HWRESET)
    else $error("reset pin acted outside normal state");

  AST_SOFT_END: assert property (
    st_r.state == meter_reset_pkg::SEQ_SWRESET && sup_s
    |=> !st_r.setup[`SOFT_RESET_BIT] && st_r.done && $stable(st_r.port_cfg))
    else $error("soft reset end wrong");

  AST_SOFT_IGNORE: assert property (
    st_r.state != meter_reset_pkg::SEQ_NORMAL
    |-> st_nxt.state != meter_reset_pkg::SEQ_SWRESET)
    else $error("soft reset outside normal state");

  COV_WAKE: cover property (
    st_r.state == meter_reset_pkg::SEQ_WAKE ##1 st_r.state == meter_reset_pkg::SEQ_NORMAL);
  COV_SPI: cover property ($rose(st_r.spi));
  COV_HWRST: cover property (st_r.state == meter_reset_pkg::SEQ_HWRESET && st_r.cnt == RST_MIN);
  COV_SOFT_RESET_BIT: cover property (st_r.state == meter_reset_pkg::SEQ_SWRESET);

endmodule : meter_reset_port_sequencer

`default_nettype wire

// [sim/host_pin_model.sv]
// Host-side model driving the mode, reset and port-select pins and the register link
`timescale 1ns/100ps
`default_nettype none
`include "meter_reset_params.svh"

module host_pin_model (
  input  wire logic               clk,
  output logic                    link_clk,
  output logic                    link_wr_en,
  output logic      [`ADDR_W-1:0] link_addr,
  output logic      [`REG_W-1:0]  link_wdata,
  output logic                    supply_ok,
  output logic                    power_mode_pin_zero,
  output logic                    power_mode_pin_one,
  output logic                    reset_pin_n,
  output logic                    port_select_pin
);
  logic link_run;

  initial begin
    link_clk = 1'b0;
    link_run = 1'b0;
    link_wr_en = 1'b0;
    link_addr = 3'h0;
    link_wdata = 16'h0000;
    supply_ok = 1'b1;
    power_mode_pin_zero = 1'b1;
    power_mode_pin_one = 1'b1;
    reset_pin_n = 1'b1;
    port_select_pin = 1'b1;
  end

  // Link clock runs only while a write is in flight
  always begin
    #7.5;
    if (link_run) begin
      link_clk = ~link_clk;
    end
  end

  // Address and data stay put after the write for the toggle crossing
  task automatic write(input logic [`ADDR_W-1:0] a, input logic [`REG_W-1:0] d);
    link_run = 1'b1;
    @(posedge link_clk);
    link_wr_en <= 1'b1;
    link_addr <= a;
    link_wdata <= d;
    @(posedge link_clk);
    link_wr_en <= 1'b0;
    @(posedge link_clk);
    @(negedge link_clk);
    link_run = 1'b0;
  endtask : write

  task automatic set_mode(input logic one, input logic zero);
    @(posedge clk);
    power_mode_pin_one <= one;
    power_mode_pin_zero <= zero;
  endtask : set_mode

  task automatic set_supply(input logic v);
    @(posedge clk);
    supply_ok <= v;
  endtask : set_supply

  task automatic pulse_reset(input int cyc);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    reset_pin_n <= 1'b1;
  endtask : pulse_reset

  task automatic toggle_select(input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      port_select_pin <= 1'b0;
      repeat (4) @(posedge clk);
      port_select_pin <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : toggle_select
endmodule : host_pin_model
`default_nettype wire

// [sim/meter_reset_port_sequencer_tb.sv]
// Self-checking bench for the reset and serial-port sequencer
`timescale 1ns/100ps
`default_nettype none
`include "meter_reset_params.svh"

module meter_reset_port_sequencer_tb;
  localparam int          HOLD      = 50;
  localparam int          WAKE      = 80;
  localparam logic [15:0] OCUR_INIT = 16'h00A5;

  logic clk, rst, link_clk, link_wr_en, supply_ok, pm_zero, pm_one, reset_pin_n, psel;
  logic [`ADDR_W-1:0] link_addr;
  logic [15:0] link_wdata, status_one, main_setup, port_config, ocur;
  logic chip_active, irq_n, spi_selected, port_locked, dsp_run, dload;
  meter_reset_pkg::power_mode_e power_state;
  int mismatches, check_count, cycles, n, load_count;

  always #20 clk = ~clk;

  host_pin_model host (.clk(clk), .link_clk(link_clk), .link_wr_en(link_wr_en),
    .link_addr(link_addr), .link_wdata(link_wdata), .supply_ok(supply_ok),
    .power_mode_pin_zero(pm_zero), .power_mode_pin_one(pm_one),
    .reset_pin_n(reset_pin_n), .port_select_pin(psel));

  meter_reset_port_sequencer #(.HOLD_CYC(HOLD), .WAKE_CYC(WAKE), .OCUR_RESET(OCUR_INIT)) dut (
    .clk(clk), .rst(rst), .link_clk(link_clk), .supply_ok(supply_ok),
    .power_mode_pin_zero(pm_zero), .power_mode_pin_one(pm_one), .reset_pin_n(reset_pin_n),
    .port_select_pin(psel), .link_wr_en(link_wr_en), .link_addr(link_addr),
    .link_wdata(link_wdata), .chip_active(chip_active), .power_state(power_state),
    .interrupt_line_one_n(irq_n), .status_one(status_one), .main_setup(main_setup),
    .port_config(port_config), .overcurrent_threshold(ocur), .spi_selected(spi_selected),
    .port_locked(port_locked), .dsp_run(dsp_run), .defaults_load(dload));

  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [15:0] d);
    host.write(a, d);
    tick(8);
  endtask : wr

  task automatic wait_normal(output int cnt);
    cnt = 0;
    while (power_state !== meter_reset_pkg::PM_NORMAL && cnt < 400) begin
      tick(1);
      cnt++;
    end
    tick(2);
  endtask : wait_normal

  task automatic wait_active(output int cnt);
    cnt = 0;
    while (chip_active !== 1'b1 && cnt < 200) begin
      tick(1);
      cnt++;
    end
  endtask : wait_active

  // Counts one-cycle default-load pulses
  always @(negedge clk) begin
    if (dload === 1'b1) begin
      load_count++;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    load_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_active(n);
    chk(16'(n >= HOLD && n <= HOLD + 4), 16'h0001);
    chk(16'(power_state), 16'(meter_reset_pkg::PM_SLEEP));
    host.set_mode(1'b0, 1'b1);
    tick(4);
    chk(status_one, 16'h0000);
    wait_normal(n);
    chk(16'(n + 4 <= WAKE + 5), 16'h0001);
    chk(status_one, 16'h8000);
    chk(16'(irq_n), 16'h0000);
    chk(16'(spi_selected), 16'h0000);
    chk(16'(dsp_run), 16'h0000);
    chk(port_config, `PORT_CFG_DEFAULT);
    chk(ocur, OCUR_INIT);
    chk(16'(load_count), 16'h0001);
    wr(`ADDR_STATUS_ONE, 16'h7FFF);
    chk(status_one, 16'h8000);
    wr(`ADDR_STATUS_ONE, 16'h8000);
    chk(status_one, 16'h0000);
    chk(16'(irq_n), 16'h0001);
    repeat (3) wr(`ADDR_OCUR, 16'h1234);
    wr(`ADDR_RUN, `RUN_START);
    chk(16'(dsp_run), 16'h0001);
    host.toggle_select(2);
    tick(6);
    chk(16'(spi_selected), 16'h0000);
    host.toggle_select(1);
    tick(6);
    chk(16'(spi_selected), 16'h0001);
    wr(`ADDR_PORT_CFG, 16'h0004);
    chk(16'(port_locked), 16'h0001);
    host.set_mode(1'b0, 1'b0);
    tick(6);
    chk(16'(power_state), 16'(meter_reset_pkg::PM_RED_A));
    host.set_mode(1'b1, 1'b0);
    tick(6);
    chk(16'(power_state), 16'(meter_reset_pkg::PM_RED_B));
    host.pulse_reset(260);
    tick(8);
    chk(16'(spi_selected), 16'h0001);
    wr(`ADDR_MAIN_SETUP, 16'h0080);
    chk(main_setup, 16'h0000);
    chk(status_one, 16'h0000);
    host.set_mode(1'b0, 1'b1);
    wait_normal(n);
    chk(16'(n <= WAKE + 5), 16'h0001);
    chk(16'(spi_selected), 16'h0001);
    chk(16'(port_locked), 16'h0001);
    wr(`ADDR_STATUS_ONE, 16'h8000);
    wr(`ADDR_RUN, `RUN_START);
    wr(`ADDR_MAIN_SETUP, 16'h0080);
    chk(main_setup, 16'h0000);
    chk(status_one, 16'h8000);
    chk(16'(irq_n), 16'h0000);
    chk(16'(dsp_run), 16'h0000);
    chk(ocur, 16'h1234);
    chk(port_config, 16'h0004);
    chk(16'(spi_selected), 16'h0001);
    chk(16'(load_count), 16'h0003);
    wr(`ADDR_STATUS_ONE, 16'h8000);
    host.pulse_reset(100);
    tick(8);
    chk(16'(spi_selected), 16'h0001);
    chk(status_one, 16'h0000);
    chk(16'(load_count), 16'h0003);
    host.pulse_reset(260);
    tick(8);
    chk(16'(spi_selected), 16'h0000);
    chk(16'(port_locked), 16'h0000);
    chk(port_config, `PORT_CFG_DEFAULT);
    chk(ocur, OCUR_INIT);
    chk(16'(load_count), 16'h0004);
    chk(status_one, 16'h8000);
    chk(16'(dsp_run), 16'h0000);
    wr(`ADDR_STATUS_ONE, 16'h8000);
    wr(`ADDR_PORT_CFG, 16'h0002);
    chk(16'(port_locked), 16'h0001);
    host.toggle_select(3);
    tick(6);
    chk(16'(spi_selected), 16'h0000);
    host.set_supply(1'b0);
    tick(6);
    chk(16'(chip_active), 16'h0000);
    chk(16'(port_locked), 16'h0000);
    host.set_supply(1'b1);
    rst <= 1'b1;
    tick(3);
    chk(16'(irq_n), 16'h0001);
    chk(16'(chip_active), 16'h0000);
    @(posedge clk);
    rst <= 1'b0;
    wait_active(n);
    chk(16'(n >= HOLD && n <= HOLD + 4), 16'h0001);
    chk(16'(power_state), 16'(meter_reset_pkg::PM_SLEEP));
    chk(16'(spi_selected), 16'h0000);
    wrap_up();
  end
endmodule : meter_reset_port_sequencer_tb
`default_nettype wire
